// File: lfs_consts.svh
// field positions, register offsets and reset values of the training field source
// assumes inclusion by bare name from each design file that uses its macros
`ifndef LFS_CONSTS_SVH
`define LFS_CONSTS_SVH
// control block of a training frame
`define LFS_CTL_PRESET_BIT 13
`define LFS_CTL_INIT_BIT 12
// coefficient fields, same positions in control and status blocks
`define LFS_FLD_POST_LSB 4
`define LFS_FLD_MAIN_LSB 2
`define LFS_FLD_PRE_LSB 0
// tap register: commands low, reports from this bit up
`define LFS_TAPS_REP_LSB 8
// control register bits
`define LFS_CTRL_EN_BIT 0
`define LFS_CTRL_RESTART_BIT 1
// preset and initialize register fields
`define LFS_PI_PRESET_LSB 0
`define LFS_PI_INIT_LSB 4
// register byte offsets
`define LFS_REG_CTRL 8'h00
`define LFS_REG_PRESET_INIT 8'h04
`define LFS_REG_LANE0_SEED 8'h08
`define LFS_REG_LANE1_SEED 8'h0c
`define LFS_REG_LANE0_TAPS 8'h10
`define LFS_REG_LANE1_TAPS 8'h14
`define LFS_REG_STATUS 8'h18
// reset values
`define LFS_RST_SEED0 11'h001
`define LFS_RST_SEED1 11'h002
`endif

// File: lfs_pkg.sv
// types shared by the training field source and its lane module
// assumes lfs_consts.svh is compiled alongside
package lfs_pkg;
	typedef enum logic [1:0] {
		LFS_MISSION = 2'b00,
		LFS_LOAD = 2'b01,
		LFS_TRAIN = 2'b11
	} lfs_state_t;

	typedef struct packed {
		logic [10:0] lfsr;
		logic [15:0] ctrl;
		logic [15:0] stat;
		logic pbit;
	} lfs_lane_st_t;

	typedef struct packed {
		lfs_state_t state;
		logic restart_d;
		logic restart_pulse;
		logic en;
		logic [3:0] preset;
		logic [3:0] init;
		logic [10:0] seed0;
		logic [10:0] seed1;
		logic [5:0] cmd0;
		logic [5:0] rep0;
		logic [5:0] cmd1;
		logic [5:0] rep1;
		logic [31:0] rdata;
	} lfs_top_st_t;
endpackage

// File: lfs_lane.sv
// one lane: pattern generator and the frame control and status words
// assumes frame_start comes from the frame transmitter on the same clock
`timescale 1ns/1ps
`include "lfs_consts.svh"
module lfs_lane (
	input wire logic clk,
	input wire logic srst,
	input wire logic load_seed,
	input wire logic run,
	input wire logic frame_start,
	input wire logic preset,
	input wire logic init,
	input wire logic [1:0] post_cmd,
	input wire logic [1:0] main_cmd,
	input wire logic [1:0] pre_cmd,
	input wire logic [1:0] post_rep,
	input wire logic [1:0] main_rep,
	input wire logic [1:0] pre_rep,
	input wire logic [10:0] seed,
	output logic [15:0] ctrl_word,
	output logic [15:0] stat_word,
	output logic pattern_bit
);
	lfs_pkg::lfs_lane_st_t s;
	lfs_pkg::lfs_lane_st_t next_s;

	always_comb
	begin
		next_s = s;
		if (load_seed)
			next_s.lfsr = seed;
		else if (run)
			next_s.lfsr = {s.lfsr[9:0], s.lfsr[10] ^ s.lfsr[8]};
		next_s.pbit = run ? s.lfsr[10] : 1'b0;
		if (!run)
		begin
			next_s.ctrl = '0;
			next_s.stat = '0;
		end
		else if (frame_start)
		begin
			// fields sampled once per frame so a frame stays consistent
			next_s.ctrl = '0;
			next_s.stat = '0;
			next_s.ctrl[`LFS_CTL_PRESET_BIT] = preset;
			next_s.ctrl[`LFS_CTL_INIT_BIT] = init;
			next_s.ctrl[`LFS_FLD_POST_LSB +: 2] = post_cmd;
			next_s.ctrl[`LFS_FLD_MAIN_LSB +: 2] = main_cmd;
			next_s.ctrl[`LFS_FLD_PRE_LSB +: 2] = pre_cmd;
			next_s.stat[`LFS_FLD_POST_LSB +: 2] = post_rep;
			next_s.stat[`LFS_FLD_MAIN_LSB +: 2] = main_rep;
			next_s.stat[`LFS_FLD_PRE_LSB +: 2] = pre_rep;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			s <= '0;
		else
			s <= next_s;
	end

	assign ctrl_word = s.ctrl;
	assign stat_word = s.stat;
	assign pattern_bit = s.pbit;

	chk_seed_load: assert property (@(posedge clk) disable iff (srst)
		load_seed |=> s.lfsr == $past(seed))
		else $error("seed not loaded into pattern generator");
	chk_ctrl_fields: assert property (@(posedge clk) disable iff (srst)
		run && frame_start |=> ctrl_word[5:0] == $past({post_cmd, main_cmd, pre_cmd}))
		else $error("coefficient commands wrong in control block");
	chk_stat_fields: assert property (@(posedge clk) disable iff (srst)
		run && frame_start |=> stat_word[5:0] == $past({post_rep, main_rep, pre_rep}))
		else $error("coefficient reports wrong in status block");
	chk_init_bit: assert property (@(posedge clk) disable iff (srst)
		run && frame_start ##1 run && !frame_start |=> $stable(ctrl_word[`LFS_CTL_INIT_BIT]))
		else $error("initialize bit changed between frames");
	chk_idle_quiet: assert property (@(posedge clk) disable iff (srst)
		!run |=> ctrl_word == 16'h0000 && stat_word == 16'h0000 && !pattern_bit)
		else $error("lane words not cleared outside training");
endmodule // lfs_lane

// File: lfs_field_source.sv
// training frame field source for lanes 0 and 1 with a training sequencer
// assumes all inputs, frame_start included, are on clk; plain register port
`timescale 1ns/1ps
`include "lfs_consts.svh"
// Operation
// - 4-bit preset request drives the preset bit of each control block.
// - 4-bit initialize request drives the initialize bit of each control block.
// - each lane's 11-bit seed loads that lane's pattern generator.
// - per-lane post-tap command sets the k+1 update field in control block.
// - per-lane main-tap command sets the k0 update field in control block.
// - per-lane pre-tap command sets the k-1 update field in control block.
// - per-lane post-tap report sets the k+1 status in status block.
// - per-lane main-tap report sets the k0 status in status block.
// - per-lane pre-tap report sets the k-1 status in status block.
// - field ports are used only in the variant without register interface.
// - training enable low bypasses training; all lanes in mission mode.
// - restart request starts training over from any state while training enable is high.
module lfs_field_source #(
	parameter bit USE_REG_IF = 1'b0
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic link_train_on,
	input wire logic link_train_restart_req,
	input wire logic [3:0] train_preset_request,
	input wire logic [3:0] train_init_request,
	input wire logic [10:0] lane0_pattern_seed,
	input wire logic [10:0] lane1_pattern_seed,
	input wire logic [1:0] lane0_post_tap_cmd,
	input wire logic [1:0] lane0_main_tap_cmd,
	input wire logic [1:0] lane0_pre_tap_cmd,
	input wire logic [1:0] lane0_post_tap_report,
	input wire logic [1:0] lane0_main_tap_report,
	input wire logic [1:0] lane0_pre_tap_report,
	input wire logic [1:0] lane1_post_tap_cmd,
	input wire logic [1:0] lane1_main_tap_cmd,
	input wire logic [1:0] lane1_pre_tap_cmd,
	input wire logic [1:0] lane1_post_tap_report,
	input wire logic [1:0] lane1_main_tap_report,
	input wire logic [1:0] lane1_pre_tap_report,
	input wire logic frame_start,
	output logic mission_mode,
	output logic training_active,
	output logic [15:0] lane0_ctrl_word,
	output logic [15:0] lane0_stat_word,
	output logic lane0_pattern_bit,
	output logic [15:0] lane1_ctrl_word,
	output logic [15:0] lane1_stat_word,
	output logic lane1_pattern_bit
);
	lfs_pkg::lfs_top_st_t s;
	lfs_pkg::lfs_top_st_t next_s;

	logic en_eff;
	logic restart_ev;
	logic [3:0] cfg_preset;
	logic [3:0] cfg_init;
	logic [10:0] cfg_seed0;
	logic [10:0] cfg_seed1;
	logic [5:0] cfg_cmd0;
	logic [5:0] cfg_rep0;
	logic [5:0] cfg_cmd1;
	logic [5:0] cfg_rep1;
	logic load_seed;
	logic run;

	// source select: registers in one variant, ports in the other
	always_comb
	begin
		if (USE_REG_IF)
		begin
			en_eff = s.en;
			restart_ev = s.restart_pulse;
			cfg_preset = s.preset;
			cfg_init = s.init;
			cfg_seed0 = s.seed0;
			cfg_seed1 = s.seed1;
			cfg_cmd0 = s.cmd0;
			cfg_rep0 = s.rep0;
			cfg_cmd1 = s.cmd1;
			cfg_rep1 = s.rep1;
		end
		else
		begin
			// ports take effect only when no register interface is built
			en_eff = link_train_on;
			restart_ev = link_train_restart_req && !s.restart_d;
			cfg_preset = train_preset_request;
			cfg_init = train_init_request;
			cfg_seed0 = lane0_pattern_seed;
			cfg_seed1 = lane1_pattern_seed;
			cfg_cmd0 = {lane0_post_tap_cmd, lane0_main_tap_cmd, lane0_pre_tap_cmd};
			cfg_rep0 = {lane0_post_tap_report, lane0_main_tap_report, lane0_pre_tap_report};
			cfg_cmd1 = {lane1_post_tap_cmd, lane1_main_tap_cmd, lane1_pre_tap_cmd};
			cfg_rep1 = {lane1_post_tap_report, lane1_main_tap_report, lane1_pre_tap_report};
		end
	end

	always_comb
	begin
		next_s = s;
		next_s.restart_d = link_train_restart_req;
		next_s.restart_pulse = 1'b0;
		next_s.rdata = 32'h0000_0000;

		// sequencer
		if (!en_eff)
			next_s.state = lfs_pkg::LFS_MISSION;
		else if (restart_ev)
			next_s.state = lfs_pkg::LFS_LOAD;
		else
		begin
			unique case (s.state)
				lfs_pkg::LFS_MISSION: next_s.state = lfs_pkg::LFS_LOAD;
				lfs_pkg::LFS_LOAD: next_s.state = lfs_pkg::LFS_TRAIN;
				lfs_pkg::LFS_TRAIN: next_s.state = lfs_pkg::LFS_TRAIN;
				default: next_s.state = lfs_pkg::LFS_MISSION;
			endcase
		end

		// register writes
		if (reg_wr)
		begin
			unique case (reg_addr)
				`LFS_REG_CTRL:
				begin
					next_s.en = reg_wdata[`LFS_CTRL_EN_BIT];
					next_s.restart_pulse = reg_wdata[`LFS_CTRL_RESTART_BIT];
				end
				`LFS_REG_PRESET_INIT:
				begin
					next_s.preset = reg_wdata[`LFS_PI_PRESET_LSB +: 4];
					next_s.init = reg_wdata[`LFS_PI_INIT_LSB +: 4];
				end
				`LFS_REG_LANE0_SEED: next_s.seed0 = reg_wdata[10:0];
				`LFS_REG_LANE1_SEED: next_s.seed1 = reg_wdata[10:0];
				`LFS_REG_LANE0_TAPS:
				begin
					next_s.cmd0 = reg_wdata[5:0];
					next_s.rep0 = reg_wdata[`LFS_TAPS_REP_LSB +: 6];
				end
				`LFS_REG_LANE1_TAPS:
				begin
					next_s.cmd1 = reg_wdata[5:0];
					next_s.rep1 = reg_wdata[`LFS_TAPS_REP_LSB +: 6];
				end
				default:
				begin
				end
			endcase
		end

		// register reads, answered the next cycle; unmapped reads give zero
		if (reg_rd)
		begin
			unique case (reg_addr)
				`LFS_REG_CTRL: next_s.rdata[`LFS_CTRL_EN_BIT] = s.en;
				`LFS_REG_PRESET_INIT:
				begin
					next_s.rdata[`LFS_PI_PRESET_LSB +: 4] = s.preset;
					next_s.rdata[`LFS_PI_INIT_LSB +: 4] = s.init;
				end
				`LFS_REG_LANE0_SEED: next_s.rdata[10:0] = s.seed0;
				`LFS_REG_LANE1_SEED: next_s.rdata[10:0] = s.seed1;
				`LFS_REG_LANE0_TAPS:
				begin
					next_s.rdata[5:0] = s.cmd0;
					next_s.rdata[`LFS_TAPS_REP_LSB +: 6] = s.rep0;
				end
				`LFS_REG_LANE1_TAPS:
				begin
					next_s.rdata[5:0] = s.cmd1;
					next_s.rdata[`LFS_TAPS_REP_LSB +: 6] = s.rep1;
				end
				`LFS_REG_STATUS:
				begin
					next_s.rdata[1:0] = s.state;
					next_s.rdata[2] = s.state == lfs_pkg::LFS_MISSION;
					next_s.rdata[3] = s.state == lfs_pkg::LFS_TRAIN;
				end
				default: next_s.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			s <= '0;
			s.state <= lfs_pkg::LFS_MISSION;
			s.seed0 <= `LFS_RST_SEED0;
			s.seed1 <= `LFS_RST_SEED1;
		end
		else
			s <= next_s;
	end

	assign load_seed = s.state == lfs_pkg::LFS_LOAD;
	assign run = s.state == lfs_pkg::LFS_TRAIN;
	assign mission_mode = s.state == lfs_pkg::LFS_MISSION;
	assign training_active = run;
	assign reg_rdata = s.rdata;

	// lane 0 takes bit 0 and lane-0 inputs only
	lfs_lane u_lane0 (
		.clk(clk),
		.srst(srst),
		.load_seed(load_seed),
		.run(run),
		.frame_start(frame_start),
		.preset(cfg_preset[0]),
		.init(cfg_init[0]),
		.post_cmd(cfg_cmd0[5:4]),
		.main_cmd(cfg_cmd0[3:2]),
		.pre_cmd(cfg_cmd0[1:0]),
		.post_rep(cfg_rep0[5:4]),
		.main_rep(cfg_rep0[3:2]),
		.pre_rep(cfg_rep0[1:0]),
		.seed(cfg_seed0),
		.ctrl_word(lane0_ctrl_word),
		.stat_word(lane0_stat_word),
		.pattern_bit(lane0_pattern_bit)
	);

	// lane 1 takes bit 1 and lane-1 inputs only
	lfs_lane u_lane1 (
		.clk(clk),
		.srst(srst),
		.load_seed(load_seed),
		.run(run),
		.frame_start(frame_start),
		.preset(cfg_preset[1]),
		.init(cfg_init[1]),
		.post_cmd(cfg_cmd1[5:4]),
		.main_cmd(cfg_cmd1[3:2]),
		.pre_cmd(cfg_cmd1[1:0]),
		.post_rep(cfg_rep1[5:4]),
		.main_rep(cfg_rep1[3:2]),
		.pre_rep(cfg_rep1[1:0]),
		.seed(cfg_seed1),
		.ctrl_word(lane1_ctrl_word),
		.stat_word(lane1_stat_word),
		.pattern_bit(lane1_pattern_bit)
	);

	chk_mission_bypass: assert property (@(posedge clk) disable iff (srst)
		!en_eff |=> mission_mode && !training_active)
		else $error("training not bypassed while disabled");
	chk_restart_reload: assert property (@(posedge clk) disable iff (srst)
		en_eff && restart_ev |=> s.state == lfs_pkg::LFS_LOAD)
		else $error("restart did not reload the sequence");
	chk_load_then_train: assert property (@(posedge clk) disable iff (srst)
		s.state == lfs_pkg::LFS_LOAD && en_eff && !restart_ev |=> training_active)
		else $error("training did not follow seed load");
	chk_lane0_preset: assert property (@(posedge clk) disable iff (srst)
		run && frame_start |=> lane0_ctrl_word[`LFS_CTL_PRESET_BIT] == $past(cfg_preset[0]))
		else $error("lane 0 preset bit wrong");
	chk_lane1_init: assert property (@(posedge clk) disable iff (srst)
		run && frame_start |=> lane1_ctrl_word[`LFS_CTL_INIT_BIT] == $past(cfg_init[1]))
		else $error("lane 1 initialize bit not from bit 1");
	chk_lane1_main: assert property (@(posedge clk) disable iff (srst)
		run && frame_start |=> lane1_ctrl_word[3:2] == $past(cfg_cmd1[3:2]))
		else $error("lane 1 k0 command wrong");
	chk_lane0_pre_rep: assert property (@(posedge clk) disable iff (srst)
		run && frame_start |=> lane0_stat_word[1:0] == $past(cfg_rep0[1:0]))
		else $error("lane 0 k-1 report wrong");
	chk_lane1_main_rep: assert property (@(posedge clk) disable iff (srst)
		run && frame_start |=> lane1_stat_word[3:2] == $past(cfg_rep1[3:2]))
		else $error("lane 1 k0 report wrong");
	chk_lane0_post_cmd: assert property (@(posedge clk) disable iff (srst)
		run && frame_start |=> lane0_ctrl_word[5:4] == $past(cfg_cmd0[5:4]))
		else $error("lane 0 k+1 command wrong");
	chk_lane1_pre_cmd: assert property (@(posedge clk) disable iff (srst)
		run && frame_start |=> lane1_ctrl_word[1:0] == $past(cfg_cmd1[1:0]))
		else $error("lane 1 k-1 command wrong");
	chk_lane0_post_rep: assert property (@(posedge clk) disable iff (srst)
		run && frame_start |=> lane0_stat_word[5:4] == $past(cfg_rep0[5:4]))
		else $error("lane 0 k+1 report wrong");
	chk_status_read: assert property (@(posedge clk) disable iff (srst)
		reg_rd && reg_addr == `LFS_REG_STATUS |=> reg_rdata[2] == $past(mission_mode))
		else $error("status read does not show mission mode");
	chk_status_train: assert property (@(posedge clk) disable iff (srst)
		reg_rd && reg_addr == `LFS_REG_STATUS |=> reg_rdata[3] == $past(training_active))
		else $error("status read does not show training");
	chk_mission_exit: assert property (@(posedge clk) disable iff (srst)
		en_eff && mission_mode |=> s.state == lfs_pkg::LFS_LOAD)
		else $error("enabled sequencer did not leave mission mode");
	chk_idle_words: assert property (@(posedge clk) disable iff (srst)
		!run |=> lane0_ctrl_word == 16'h0000 && lane1_stat_word == 16'h0000 && !lane1_pattern_bit)
		else $error("lane outputs not quiet outside training");
	chk_words_hold: assert property (@(posedge clk) disable iff (srst)
		run && !frame_start |=> $stable(lane0_ctrl_word) && $stable(lane1_stat_word))
		else $error("frame words changed between frame starts");

	// remaining field placements, one per lane and field
	chk_lane0_init: assert property (@(posedge clk) disable iff (srst)
		run && frame_start |=> lane0_ctrl_word[`LFS_CTL_INIT_BIT] == $past(cfg_init[0]))
		else $error("lane 0 initialize bit wrong");
	chk_lane1_preset: assert property (@(posedge clk) disable iff (srst)
		run && frame_start |=> lane1_ctrl_word[`LFS_CTL_PRESET_BIT] == $past(cfg_preset[1]))
		else $error("lane 1 preset bit not from bit 1");
	chk_lane0_main: assert property (@(posedge clk) disable iff (srst)
		run && frame_start |=> lane0_ctrl_word[3:2] == $past(cfg_cmd0[3:2]))
		else $error("lane 0 k0 command wrong");
	chk_lane1_post_cmd: assert property (@(posedge clk) disable iff (srst)
		run && frame_start |=> lane1_ctrl_word[5:4] == $past(cfg_cmd1[5:4]))
		else $error("lane 1 k+1 command wrong");
	chk_lane0_pre_cmd: assert property (@(posedge clk) disable iff (srst)
		run && frame_start |=> lane0_ctrl_word[1:0] == $past(cfg_cmd0[1:0]))
		else $error("lane 0 k-1 command wrong");
	chk_lane1_post_rep: assert property (@(posedge clk) disable iff (srst)
		run && frame_start |=> lane1_stat_word[5:4] == $past(cfg_rep1[5:4]))
		else $error("lane 1 k+1 report wrong");
	chk_lane0_main_rep: assert property (@(posedge clk) disable iff (srst)
		run && frame_start |=> lane0_stat_word[3:2] == $past(cfg_rep0[3:2]))
		else $error("lane 0 k0 report wrong");
	chk_lane1_pre_rep: assert property (@(posedge clk) disable iff (srst)
		run && frame_start |=> lane1_stat_word[1:0] == $past(cfg_rep1[1:0]))
		else $error("lane 1 k-1 report wrong");

	generate
		if (!USE_REG_IF)
		begin : g_port_src
			chk_port_source: assert property (@(posedge clk) disable iff (srst)
				run && frame_start |=> lane0_stat_word[3:2] == $past(lane0_main_tap_report))
				else $error("port report not used without registers");
		end
		else
		begin : g_reg_src
			chk_reg_source: assert property (@(posedge clk) disable iff (srst)
				run && frame_start |=> lane0_stat_word[3:2] == $past(s.rep0[3:2]))
				else $error("register report not used with registers");
		end
	endgenerate
endmodule // lfs_field_source

// File: lfs_frame_tx.sv
// frame transmitter model: pulses frame_start and captures the words it sends
// assumes the field source samples frame_start on the same clk
`timescale 1ns/1ps
module lfs_frame_tx #(
	parameter int GAP = 5
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic enable,
	input wire logic [63:0] words,
	output logic frame_start,
	output logic [7:0] frames,
	output logic [63:0] cap
);
	int cnt;
	logic pend;
	// words are taken one cycle after frame_start, once the source updated them
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			cnt <= 0;
			frame_start <= 1'b0;
			pend <= 1'b0;
			frames <= 8'h00;
			cap <= 64'h0;
		end
		else
		begin
			cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
			frame_start <= enable && cnt == 0;
			pend <= frame_start;
			if (pend)
			begin
				cap <= words;
				frames <= frames + 8'h01;
			end
		end
	end
endmodule // lfs_frame_tx

// File: test_lfs_field_source.sv
// testbench of the training field source, port variant and register variant
// assumes lfs_frame_tx stands in for the frame transmitter shared by both
`timescale 1ns/1ps
`include "lfs_consts.svh"
module test_lfs_field_source;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic train_on = 1'b0;
	logic restart = 1'b0;
	logic [3:0] preset = 4'h0;
	logic [3:0] init = 4'h0;
	logic [10:0] seed0 = 11'h5a3;
	logic [10:0] seed1 = 11'h2c6;
	logic [1:0] t0 [0:5] = '{default: 2'h0};
	logic [1:0] t1 [0:5] = '{default: 2'h0};
	logic tx_en = 1'b0;
	logic frame_start, mission_mode, training_active, pat0, pat1;
	logic [15:0] c0, s0, c1, s1;
	logic [7:0] frames;
	logic [63:0] cap;
	logic [31:0] e0, e1;
	logic [31:0] r_rdata;
	logic r_mission, r_active, rpat0, rpat1;
	logic [15:0] rc0, rs0, rc1, rs1;
	int errors = 0;
	int samples_checked = 0;

	always #12.5 clk = ~clk;

	lfs_field_source #(.USE_REG_IF(1'b0)) i_dut (
		.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.link_train_on(train_on), .link_train_restart_req(restart),
		.train_preset_request(preset), .train_init_request(init),
		.lane0_pattern_seed(seed0), .lane1_pattern_seed(seed1),
		.lane0_post_tap_cmd(t0[0]), .lane0_main_tap_cmd(t0[1]), .lane0_pre_tap_cmd(t0[2]),
		.lane0_post_tap_report(t0[3]), .lane0_main_tap_report(t0[4]),
		.lane0_pre_tap_report(t0[5]),
		.lane1_post_tap_cmd(t1[0]), .lane1_main_tap_cmd(t1[1]), .lane1_pre_tap_cmd(t1[2]),
		.lane1_post_tap_report(t1[3]), .lane1_main_tap_report(t1[4]),
		.lane1_pre_tap_report(t1[5]),
		.frame_start(frame_start), .mission_mode(mission_mode),
		.training_active(training_active), .lane0_ctrl_word(c0), .lane0_stat_word(s0),
		.lane0_pattern_bit(pat0), .lane1_ctrl_word(c1), .lane1_stat_word(s1),
		.lane1_pattern_bit(pat1)
	);

	// register variant on the same bus and pins; it must ignore the field pins
	lfs_field_source #(.USE_REG_IF(1'b1)) i_dut_reg (
		.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(r_rdata),
		.link_train_on(train_on), .link_train_restart_req(restart),
		.train_preset_request(preset), .train_init_request(init),
		.lane0_pattern_seed(seed0), .lane1_pattern_seed(seed1),
		.lane0_post_tap_cmd(t0[0]), .lane0_main_tap_cmd(t0[1]), .lane0_pre_tap_cmd(t0[2]),
		.lane0_post_tap_report(t0[3]), .lane0_main_tap_report(t0[4]),
		.lane0_pre_tap_report(t0[5]),
		.lane1_post_tap_cmd(t1[0]), .lane1_main_tap_cmd(t1[1]), .lane1_pre_tap_cmd(t1[2]),
		.lane1_post_tap_report(t1[3]), .lane1_main_tap_report(t1[4]),
		.lane1_pre_tap_report(t1[5]),
		.frame_start(frame_start), .mission_mode(r_mission),
		.training_active(r_active), .lane0_ctrl_word(rc0), .lane0_stat_word(rs0),
		.lane0_pattern_bit(rpat0), .lane1_ctrl_word(rc1), .lane1_stat_word(rs1),
		.lane1_pattern_bit(rpat1)
	);

	lfs_frame_tx #(.GAP(5)) i_tx (
		.clk(clk), .srst(srst), .enable(tx_en), .words({c0, c1, s0, s1}),
		.frame_start(frame_start), .frames(frames), .cap(cap)
	);

	task end_of_test;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task reg_check(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask

	task wait_train(input logic want);
		for (int n = 0; n < 20 && training_active !== want; n++)
		begin
			@(posedge clk);
			#1;
		end
		if (training_active !== want)
		begin
			errors++;
			end_of_test();
		end
	endtask

	// pattern leaves each lane msb of its own seed first
	task pattern_check;
		for (int i = 10; i >= 0; i--)
		begin
			@(posedge clk);
			#1;
			check({pat1, pat0}, {seed1[i], seed0[i]});
		end
	endtask

	// waits for two captured frames, so the second is built from the newest fields
	task wait_frames;
		int f;
		f = frames;
		for (int n = 0; n < 40 && frames != f + 2; n++)
		begin
			@(posedge clk);
			#1;
		end
		if (frames != f + 2)
		begin
			errors++;
			end_of_test();
		end
	endtask

	// new fields, held unchanged across both frames
	task fields(input logic [1:0] v);
		@(posedge clk);
		preset <= {2'b11, v};
		init <= {2'b11, v[0], v[1]};
		for (int k = 0; k < 6; k++)
		begin
			t0[k] <= v + k[1:0];
			t1[k] <= ~(v + k[1:0]);
		end
		#1;
		wait_frames();
	endtask

	initial
	begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		#1;
		check({mission_mode, training_active, pat0, pat1}, 4'h8);
		reg_check(`LFS_REG_STATUS, 32'h4);
		check(r_rdata, 32'h4);
		reg_check(`LFS_REG_LANE0_SEED, {21'h0, `LFS_RST_SEED0});
		reg_check(`LFS_REG_LANE1_SEED, {21'h0, `LFS_RST_SEED1});
		reg_check(8'h1c, 32'h0);
		reg_write(`LFS_REG_LANE0_TAPS, 32'h3f3f);
		reg_write(`LFS_REG_PRESET_INIT, 32'hff);
		reg_check(`LFS_REG_LANE0_TAPS, 32'h3f3f);
		reg_check(`LFS_REG_CTRL, 32'h0);
		tx_en <= 1'b1;
		fields(2'h1);
		check(cap, 64'h0);
		@(posedge clk);
		train_on <= 1'b1;
		wait_train(1'b1);
		pattern_check();
		check(mission_mode, 1'b0);
		check(r_mission, 1'b1);
		reg_check(`LFS_REG_STATUS, 32'hb);
		for (int v = 0; v < 4; v++)
		begin
			fields(v[1:0]);
			e0[31:16] = {2'b00, v[0], v[1], 6'h0, t0[0], t0[1], t0[2]};
			e0[15:0] = {2'b00, v[1], v[0], 6'h0, t1[0], t1[1], t1[2]};
			e1 = {10'h0, t0[3], t0[4], t0[5], 10'h0, t1[3], t1[4], t1[5]};
			check(cap[63:32], e0);
			check(cap[31:0], e1);
		end
		@(posedge clk);
		restart <= 1'b1;
		wait_train(1'b0);
		wait_train(1'b1);
		pattern_check();
		@(posedge clk);
		restart <= 1'b0;
		train_on <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		check({mission_mode, training_active, pat0, pat1}, 4'h8);
		check({c0, c1, s0, s1}, 64'h0);
		@(posedge clk);
		restart <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check({mission_mode, training_active}, 2'b10);
		// register variant: enable, restart and fields come from registers only
		reg_write(`LFS_REG_LANE1_TAPS, 32'h2d1b);
		reg_write(`LFS_REG_CTRL, 32'h1);
		#1;
		check({mission_mode, r_mission}, 2'b11);
		wait_frames();
		check(r_active, 1'b1);
		check({rc0, rc1, rs0, rs1}, 64'h303f_301b_003f_002d);
		reg_check(`LFS_REG_STATUS, 32'h4);
		check(r_rdata, 32'hb);
		reg_write(`LFS_REG_CTRL, 32'h3);
		@(posedge clk);
		#1;
		check({r_mission, r_active}, 2'b00);
		@(posedge clk);
		#1;
		check(r_active, 1'b1);
		reg_write(`LFS_REG_CTRL, 32'h0);
		repeat (2) @(posedge clk);
		#1;
		check({r_mission, r_active, rpat0, rpat1}, 4'h8);
		check({rc0, rc1, rs0, rs1}, 64'h0);
		end_of_test();
	end
endmodule // test_lfs_field_source
